/* File: hdl/chan_cfg_regs.svh */
`ifndef CHAN_CFG_REGS_SVH
`define CHAN_CFG_REGS_SVH

// register offsets
`define OFS_INDICATOR      5'h0E
`define OFS_TRIGGER        5'h0F
`define OFS_LINE_CFG_A     5'h10

// reset values
`define RST_INDICATOR      8'h00
`define RST_TRIGGER        4'h0
`define RST_LINE_CFG_A     8'h00
`define ZERO_BYTE          8'h00
`define ZERO_CODE          4'h0

// indicator_pin_control fields
`define BIT_READY_SEL_A    0
`define BIT_LED_ONE_A      1
`define BIT_ERR_SEL_A      2
`define BIT_LED_TWO_A      3

// transmit_start_trigger field
`define TRIG_MSB           3

// line_config_chan_a fields
`define BIT_FILTER_A       0
`define BIT_DRV_OFF_A      1
`define BIT_TOTEM_A        2
`define BIT_POLARITY_A     3
`define FLD_LEVEL_LSB      4
`define FLD_LEVEL_MSB      5
`define BIT_CUR_DIR_A      6
`define BIT_THRESH_A       7

// spi frame header and bit counts
`define HDR_READ_BIT       7
`define HDR_CHIP_MSB       6
`define HDR_CHIP_LSB       5
`define HDR_ADDR_MSB       4
`define SPI_LAST_HDR_BIT   4'h7
`define SPI_FIRST_DATA_BIT 4'h9
`define SPI_LAST_DATA_BIT  4'hF

// glitch filter timing
`define FILTER_WINDOW_NS   1300
`define CLK_PERIOD_NS      25

`endif

/* File: hdl/chan_cfg_pkg.sv */
package chan_cfg_pkg;

  typedef logic [7:0] byte_t;
  typedef logic [3:0] code_t;
  typedef logic [4:0] regaddr_t;

  typedef enum logic [1:0] {
    CUR_OFF   = 2'h0,
    CUR_5MA   = 2'h1,
    CUR_2MA   = 2'h2,
    CUR_150UA = 2'h3
  } current_level_e;

endpackage

/* File: hdl/spi_frame_if.sv */
`timescale 1ns/100ps
`default_nettype none

interface spi_frame_if;
  logic                  hdrStrobe;
  logic                  dataStrobe;
  chan_cfg_pkg::byte_t   header;
  chan_cfg_pkg::byte_t   dataByte;
  chan_cfg_pkg::byte_t   readByte;

  modport sub  (output hdrStrobe, output dataStrobe, output header, output dataByte,
                input readByte);
  modport regs (input hdrStrobe, input dataStrobe, input header, input dataByte,
                output readByte);
endinterface

`default_nettype wire

/* File: hdl/spi_frame_rx.sv */
`timescale 1ns/100ps
`default_nettype none
`include "chan_cfg_regs.svh"

module spi_frame_rx (
  input  wire logic     clk,
  input  wire logic     reset_n,
  input  wire logic     spiCsNPin,
  input  wire logic     spiSclkPin,
  input  wire logic     spiMosiPin,
  output logic          spiMisoOut,
  output logic          spiMisoOe,
  spi_frame_if.sub      frame
);

  logic [1:0]          csNSync_ff;
  logic [1:0]          sclkSync_ff;
  logic [1:0]          mosiSync_ff;
  logic                sclkLast_ff;
  logic [3:0]          bitCnt_ff;
  chan_cfg_pkg::byte_t shiftIn_ff;
  chan_cfg_pkg::byte_t shiftOut_ff;
  logic                hdrStrobe_ff;
  logic                dataStrobe_ff;
  chan_cfg_pkg::byte_t header_ff;
  chan_cfg_pkg::byte_t data_ff;

  wire                 csActive   = ~csNSync_ff[1];
  wire                 sclkRise   = csActive & sclkSync_ff[1] & ~sclkLast_ff;
  wire                 sclkFall   = csActive & ~sclkSync_ff[1] & sclkLast_ff;
  wire                 hdrDone    = sclkRise & (bitCnt_ff == `SPI_LAST_HDR_BIT);
  wire                 dataDone   = sclkRise & (bitCnt_ff == `SPI_LAST_DATA_BIT);
  wire                 outShift   = sclkFall & (bitCnt_ff >= `SPI_FIRST_DATA_BIT);
  wire [7:0]           nxt_shift  = {shiftIn_ff[6:0], mosiSync_ff[1]};

  // pin synchronisers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      csNSync_ff  <= 2'h3;
      sclkSync_ff <= 2'h0;
      mosiSync_ff <= 2'h0;
      sclkLast_ff <= 1'b0;
    end else begin
      csNSync_ff  <= {csNSync_ff[0], spiCsNPin};
      sclkSync_ff <= {sclkSync_ff[0], spiSclkPin};
      mosiSync_ff <= {mosiSync_ff[0], spiMosiPin};
      sclkLast_ff <= sclkSync_ff[1];
    end
  end

  // bit counting and byte capture
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bitCnt_ff     <= 4'h0;
      shiftIn_ff    <= `ZERO_BYTE;
      hdrStrobe_ff  <= 1'b0;
      dataStrobe_ff <= 1'b0;
      header_ff     <= `ZERO_BYTE;
      data_ff       <= `ZERO_BYTE;
    end else begin
      bitCnt_ff     <= !csActive ? 4'h0 : (sclkRise ? bitCnt_ff + 4'h1 : bitCnt_ff);
      shiftIn_ff    <= sclkRise ? nxt_shift : shiftIn_ff;
      hdrStrobe_ff  <= hdrDone;
      dataStrobe_ff <= dataDone;
      header_ff     <= hdrDone ? nxt_shift : header_ff;
      data_ff       <= dataDone ? nxt_shift : data_ff;
    end
  end

  // read data shifts out msb first on falling edges of the data byte
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shiftOut_ff <= `ZERO_BYTE;
    end else if (hdrStrobe_ff) begin
      shiftOut_ff <= frame.readByte;
    end else if (outShift) begin
      shiftOut_ff <= {shiftOut_ff[6:0], 1'b0};
    end
  end

  assign spiMisoOut       = shiftOut_ff[7];
  assign spiMisoOe        = csActive;
  assign frame.hdrStrobe  = hdrStrobe_ff;
  assign frame.dataStrobe = dataStrobe_ff;
  assign frame.header     = header_ff;
  assign frame.dataByte   = data_ff;

endmodule

`default_nettype wire

/* File: hdl/channel_pin_trigger_config_regs.sv */
`timescale 1ns/100ps
`default_nettype none
`include "chan_cfg_regs.svh"

// Overview of operation
// [R1] error-select set: fault pin asserts whenever receiver fault flag is set.
// [R2] in error-indicator mode the fault pin ignores the fault interrupt mask.
// [R3] error-select clear: fault pin is an LED driver output.
// [R4] led-one bit drives ready-pin LED, only while ready-select is clear.
// [R5] ready-select set: ready pin asserts whenever receive-data-ready flag is set.
// [R6] ready-indicator mode ignores the data-ready mask; cleared select gives LED.
// [R7] trigger register holds four write-only bits; upper four unused, reset zero.
// [R8] trigger value matching a channel's code starts its timer and message.
// [R9] trigger writes are accepted whatever device address the frame carries.
// [R10] threshold bit: 0 selects type 1, 1 selects type 2/3 thresholds.
// [R11] direction bit: 1 enables current source, 0 enables current sink.
// [R12] level field: 00 off, 01 5 mA, 10 2 mA, 11 150 uA.
// [R13] polarity bit: 1 NPN, 0 PNP; ignored in push-pull mode.
// [R14] push-pull bit: 1 push-pull driver, 0 open-drain driver.
// [R15] driver-off bit: 1 leaves line pin high impedance, 0 drives it.
// [R16] filter bit enables receiver glitch filter of about 1.3 us.
// [R17] cycle timer starts only when that channel's timer enable is set.
// [R18] a trigger matching no channel starts nothing and changes no timer.
module channel_pin_trigger_config_regs #(
  parameter int FILTER_CYCLES = `FILTER_WINDOW_NS / `CLK_PERIOD_NS
) (
  input  wire logic                          clk,
  input  wire logic                          reset_n,
  input  wire logic                          spiCsNPin,
  input  wire logic                          spiSclkPin,
  input  wire logic                          spiMosiPin,
  output logic                               spiMisoOut,
  output logic                               spiMisoOe,
  input  wire logic [1:0]                    chipAddrPin,
  input  wire logic                          rxFaultFlagA,
  input  wire logic                          rxAvailFlagA,
  output logic                               faultLedPinA,
  output logic                               availLedPinA,
  input  wire chan_cfg_pkg::code_t           startCodeAssignA,
  input  wire chan_cfg_pkg::code_t           startCodeAssignB,
  input  wire logic                          cycleTimerOnA,
  input  wire logic                          cycleTimerOnB,
  output logic                               msgStartA,
  output logic                               msgStartB,
  output logic                               timerStartA,
  output logic                               timerStartB,
  output logic                               inputThresholdTypeA,
  output logic                               currentDirA,
  output chan_cfg_pkg::current_level_e       currentLevelA,
  output logic                               currentSourceOnA,
  output logic                               currentSinkOnA,
  output logic                               lowSidePolarityA,
  output logic                               totemPoleA,
  output logic                               lineDriverOffA,
  output logic                               glitchFilterOnA,
  input  wire logic                          txDataA,
  input  wire logic                          txEnA,
  output logic                               linePinAOut,
  output logic                               linePinAOe,
  input  wire logic                          linePinAIn,
  output logic                               lineRxDataA
);

  localparam int FCW = (FILTER_CYCLES > 1) ? $clog2(FILTER_CYCLES + 1) : 1;

  if (FILTER_CYCLES < 1) begin : g_bad_filter
    $error("FILTER_CYCLES must be at least one");
  end

  function automatic logic codeMatch(input chan_cfg_pkg::code_t written,
                                     input chan_cfg_pkg::code_t assigned);
    codeMatch = (written == assigned);
  endfunction

  spi_frame_if frame ();

  spi_frame_rx u_spi_frame_rx (
    .clk        (clk),
    .reset_n    (reset_n),
    .spiCsNPin  (spiCsNPin),
    .spiSclkPin (spiSclkPin),
    .spiMosiPin (spiMosiPin),
    .spiMisoOut (spiMisoOut),
    .spiMisoOe  (spiMisoOe),
    .frame      (frame)
  );

  // registers
  chan_cfg_pkg::byte_t   indicatorCtrl_ff;
  chan_cfg_pkg::code_t   triggerValue_ff;
  logic                  trigWritten_ff;
  chan_cfg_pkg::byte_t   lineCfgA_ff;
  logic [1:0]            chipAddrSync0_ff;
  logic [1:0]            chipAddrSync1_ff;
  logic [1:0]            faultSync_ff;
  logic [1:0]            availSync_ff;
  logic [1:0]            lineInSync_ff;
  logic                  faultLed_ff;
  logic                  availLed_ff;
  logic                  msgStartA_ff;
  logic                  msgStartB_ff;
  logic                  timerStartA_ff;
  logic                  timerStartB_ff;
  logic                  lineOut_ff;
  logic                  lineOe_ff;
  logic                  filtered_ff;
  logic [FCW-1:0]        filterCnt_ff;

  // frame decode
  wire                       hdrRead     = frame.header[`HDR_READ_BIT];
  wire [1:0]                 hdrChip     = frame.header[`HDR_CHIP_MSB:`HDR_CHIP_LSB];
  wire chan_cfg_pkg::regaddr_t hdrAddr   = frame.header[`HDR_ADDR_MSB:0];
  wire                       chipHit     = (hdrChip == chipAddrSync1_ff);
  wire                       selIndicator = (hdrAddr == `OFS_INDICATOR);
  wire                       selTrigger  = (hdrAddr == `OFS_TRIGGER);
  wire                       selLineCfg  = (hdrAddr == `OFS_LINE_CFG_A);
  wire                       wrStrobe    = frame.dataStrobe & ~hdrRead;
  wire                       wrIndicator = wrStrobe & chipHit & selIndicator;
  wire                       wrLineCfg   = wrStrobe & chipHit & selLineCfg;
  wire                       wrTrigger   = wrStrobe & selTrigger; // [R9]
  wire chan_cfg_pkg::code_t  nxt_trigger = frame.dataByte[`TRIG_MSB:0]; // [R7]

  // register read-back; trigger is write-only and unmapped reads are zero
  assign frame.readByte = !chipHit     ? `ZERO_BYTE :
                          selIndicator ? indicatorCtrl_ff :
                          selLineCfg   ? lineCfgA_ff :
                          `ZERO_BYTE;

  // trigger match
  wire matchA = trigWritten_ff & codeMatch(triggerValue_ff, startCodeAssignA); // [R8]
  wire matchB = trigWritten_ff & codeMatch(triggerValue_ff, startCodeAssignB); // [R8]
  wire nxt_msgStartA   = matchA; // [R18]
  wire nxt_msgStartB   = matchB; // [R18]
  wire nxt_timerStartA = matchA & cycleTimerOnA; // [R17]
  wire nxt_timerStartB = matchB & cycleTimerOnB; // [R17]

  // indicator pin selection
  wire errSelA   = indicatorCtrl_ff[`BIT_ERR_SEL_A];
  wire readySelA = indicatorCtrl_ff[`BIT_READY_SEL_A];
  wire ledOneA   = indicatorCtrl_ff[`BIT_LED_ONE_A];
  wire ledTwoA   = indicatorCtrl_ff[`BIT_LED_TWO_A];
  // no mask input takes part here
  wire nxt_faultLed = errSelA ? faultSync_ff[1] : ledTwoA; // [R1] [R2] [R3]
  wire nxt_availLed = readySelA ? availSync_ff[1] : ledOneA; // [R4] [R5] [R6]

  // line configuration fields
  wire                        cfgThresh   = lineCfgA_ff[`BIT_THRESH_A];
  wire                        cfgCurDir   = lineCfgA_ff[`BIT_CUR_DIR_A];
  wire [1:0]                  cfgLevel    = lineCfgA_ff[`FLD_LEVEL_MSB:`FLD_LEVEL_LSB];
  wire                        cfgPolarity = lineCfgA_ff[`BIT_POLARITY_A];
  wire                        cfgTotem    = lineCfgA_ff[`BIT_TOTEM_A];
  wire                        cfgDrvOff   = lineCfgA_ff[`BIT_DRV_OFF_A];
  wire                        cfgFilter   = lineCfgA_ff[`BIT_FILTER_A];
  localparam logic [1:0]      CUR_OFF_CODE = chan_cfg_pkg::CUR_OFF;
  wire                        levelOn     = (cfgLevel != CUR_OFF_CODE);

  // line driver modes
  wire drvActive  = txEnA & ~cfgDrvOff; // [R15]
  wire odNpnDrive = drvActive & ~txDataA; // npn pulls low only
  wire odPnpDrive = drvActive & txDataA; // pnp pulls high only
  wire odDrive    = cfgPolarity ? odNpnDrive : odPnpDrive; // [R13]
  wire nxt_lineOe = cfgTotem ? drvActive : odDrive; // [R14] [R13]
  wire nxt_lineOut = cfgTotem ? txDataA : cfgPolarity ? 1'b0 : 1'b1; // [R14]

  // glitch filter
  wire                 rawLine     = lineInSync_ff[1];
  wire                 lineDiffers = (rawLine != filtered_ff);
  wire [FCW-1:0]       filterLimit = FCW'(FILTER_CYCLES);
  wire                 filterDone  = (filterCnt_ff >= filterLimit - FCW'(1));
  wire                 nxt_filtered = !cfgFilter ? rawLine :
                                      (lineDiffers & filterDone) ? rawLine : filtered_ff; // [R16]
  wire [FCW-1:0]       nxt_filterCnt = (!cfgFilter || !lineDiffers || filterDone) ?
                                       FCW'(0) : filterCnt_ff + FCW'(1); // [R16]

  // software registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      indicatorCtrl_ff <= `RST_INDICATOR;
    end else if (wrIndicator) begin
      indicatorCtrl_ff <= frame.dataByte;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      triggerValue_ff <= `RST_TRIGGER; // [R7]
      trigWritten_ff  <= 1'b0;
    end else begin
      trigWritten_ff  <= wrTrigger; // [R9]
      if (wrTrigger) begin
        triggerValue_ff <= nxt_trigger; // [R7]
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lineCfgA_ff <= `RST_LINE_CFG_A;
    end else if (wrLineCfg) begin
      lineCfgA_ff <= frame.dataByte;
    end
  end

  // pin synchronisers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chipAddrSync0_ff <= 2'h0;
      chipAddrSync1_ff <= 2'h0;
      faultSync_ff     <= 2'h0;
      availSync_ff     <= 2'h0;
      lineInSync_ff    <= 2'h0;
    end else begin
      chipAddrSync0_ff <= chipAddrPin;
      chipAddrSync1_ff <= chipAddrSync0_ff;
      faultSync_ff     <= {faultSync_ff[0], rxFaultFlagA};
      availSync_ff     <= {availSync_ff[0], rxAvailFlagA};
      lineInSync_ff    <= {lineInSync_ff[0], linePinAIn};
    end
  end

  // trigger pulses
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      msgStartA_ff   <= 1'b0;
      msgStartB_ff   <= 1'b0;
      timerStartA_ff <= 1'b0;
      timerStartB_ff <= 1'b0;
    end else begin
      msgStartA_ff   <= nxt_msgStartA; // [R8]
      msgStartB_ff   <= nxt_msgStartB; // [R8]
      timerStartA_ff <= nxt_timerStartA; // [R17]
      timerStartB_ff <= nxt_timerStartB; // [R17]
    end
  end

  // indicator and line pins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      faultLed_ff <= 1'b0;
      availLed_ff <= 1'b0;
      lineOut_ff  <= 1'b0;
      lineOe_ff   <= 1'b0;
    end else begin
      faultLed_ff <= nxt_faultLed; // [R1] [R3]
      availLed_ff <= nxt_availLed; // [R4] [R5]
      lineOut_ff  <= nxt_lineOut; // [R14]
      lineOe_ff   <= nxt_lineOe; // [R15]
    end
  end

  // glitch filter state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      filtered_ff  <= 1'b0;
      filterCnt_ff <= '0;
    end else begin
      filtered_ff  <= nxt_filtered; // [R16]
      filterCnt_ff <= nxt_filterCnt; // [R16]
    end
  end

  // outputs
  assign faultLedPinA        = faultLed_ff;
  assign availLedPinA        = availLed_ff;
  assign msgStartA           = msgStartA_ff;
  assign msgStartB           = msgStartB_ff;
  assign timerStartA         = timerStartA_ff;
  assign timerStartB         = timerStartB_ff;
  assign inputThresholdTypeA = cfgThresh; // [R10]
  assign currentDirA         = cfgCurDir;
  assign currentLevelA       = chan_cfg_pkg::current_level_e'(cfgLevel); // [R12]
  assign currentSourceOnA    = cfgCurDir & levelOn; // [R11] [R12]
  assign currentSinkOnA      = ~cfgCurDir & levelOn; // [R11] [R12]
  assign lowSidePolarityA    = cfgPolarity;
  assign totemPoleA          = cfgTotem;
  assign lineDriverOffA      = cfgDrvOff;
  assign glitchFilterOnA     = cfgFilter;
  assign linePinAOut         = lineOut_ff;
  assign linePinAOe          = lineOe_ff;
  assign lineRxDataA         = filtered_ff;

endmodule

`default_nettype wire

/* File: testbench/chan_regs_checker.sv */
`timescale 1ns/100ps
`default_nettype none

module chan_regs_checker (
  input wire logic                         clk,
  input wire logic                         reset_n,
  input wire logic                         cycleTimerOnA,
  input wire logic                         msgStartA,
  input wire logic                         timerStartA,
  input wire logic                         currentDirA,
  input wire chan_cfg_pkg::current_level_e currentLevelA,
  input wire logic                         currentSourceOnA,
  input wire logic                         currentSinkOnA,
  input wire logic                         lowSidePolarityA,
  input wire logic                         totemPoleA,
  input wire logic                         lineDriverOffA,
  input wire logic                         txDataA,
  input wire logic                         txEnA,
  input wire logic                         linePinAOut,
  input wire logic                         linePinAOe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  a_source_on:
    assert property (currentSourceOnA ==
                     (currentDirA && currentLevelA != chan_cfg_pkg::CUR_OFF))
    else $error("current source enable wrong");
  a_sink_on:
    assert property (currentSinkOnA ==
                     (!currentDirA && currentLevelA != chan_cfg_pkg::CUR_OFF))
    else $error("current sink enable wrong");
  a_timer_with_msg:
    assert property (timerStartA |-> msgStartA)
    else $error("timer start without message start");
  a_timer_enable:
    assert property (timerStartA |-> $past(cycleTimerOnA))
    else $error("timer start while timer disabled");
  a_msg_one_cycle:
    assert property (msgStartA |=> !msgStartA)
    else $error("message start longer than one cycle");
  a_push_pull:
    assert property (totemPoleA && !lineDriverOffA && txEnA |=>
                     linePinAOe && linePinAOut == $past(txDataA))
    else $error("push-pull drive wrong");
  a_open_drain:
    assert property (!totemPoleA && !lineDriverOffA && txEnA |=> linePinAOe ==
                     ($past(lowSidePolarityA) ? !$past(txDataA) : $past(txDataA)))
    else $error("open-drain enable wrong");
  a_driver_off:
    assert property (lineDriverOffA |=> !linePinAOe)
    else $error("line driven while disabled");
endmodule

bind channel_pin_trigger_config_regs chan_regs_checker u_chk (
  .clk, .reset_n, .cycleTimerOnA, .msgStartA, .timerStartA, .currentDirA,
  .currentLevelA, .currentSourceOnA, .currentSinkOnA, .lowSidePolarityA,
  .totemPoleA, .lineDriverOffA, .txDataA, .txEnA, .linePinAOut, .linePinAOe
);

`default_nettype wire

/* File: testbench/spi_host_model.sv */
`timescale 1ns/100ps
`default_nettype none

module spi_host_model (
  input  wire logic clk,
  output logic      csN,
  output logic      sclk,
  output logic      mosi,
  input  wire logic miso
);
  int half = 6;

  initial begin
    csN  = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end

  // header then data byte, msb first, sample on rise
  task automatic xfer(input logic [15:0] w, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge clk);
    csN <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      @(posedge clk);
      mosi <= w[i];
      repeat (half) @(posedge clk);
      if (i < 8) rd[i] = miso;
      sclk <= 1'b1;
      repeat (half) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (half) @(posedge clk);
    csN  <= 1'b1;
    mosi <= ~w[0];
    repeat (4) @(posedge clk);
  endtask
endmodule

`default_nettype wire

/* File: testbench/channel_pin_trigger_config_regs_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "chan_cfg_regs.svh"

module channel_pin_trigger_config_regs_tb_top;
  localparam logic [1:0] ownAddr = 2'h2;
  localparam int filtCycles = 4;
  logic clk = 1'b0;
  logic reset_n, spiCsNPin, spiSclkPin, spiMosiPin, spiMisoOut, spiMisoOe;
  logic [1:0] chipAddrPin;
  logic rxFaultFlagA, rxAvailFlagA, faultLedPinA, availLedPinA;
  chan_cfg_pkg::code_t startCodeAssignA, startCodeAssignB;
  logic cycleTimerOnA, cycleTimerOnB, msgStartA, msgStartB, timerStartA, timerStartB;
  logic inputThresholdTypeA, currentDirA, currentSourceOnA, currentSinkOnA;
  chan_cfg_pkg::current_level_e currentLevelA;
  logic lowSidePolarityA, totemPoleA, lineDriverOffA, glitchFilterOnA;
  logic txDataA, txEnA, linePinAOut, linePinAOe, lineRxDataA, lineIdle;
  logic [3:0][7:0] cnt = '0;
  logic oeHit = 1'b0;
  int n_fail = 0;
  int checks = 0;
  wire logic linePinAIn = linePinAOe ? linePinAOut : lineIdle;
  wire logic [3:0] pls = {msgStartA, timerStartA, msgStartB, timerStartB};
  wire logic [7:0] cfgOut = {inputThresholdTypeA, currentDirA, currentLevelA,
                             lowSidePolarityA, totemPoleA, lineDriverOffA, glitchFilterOnA};

  always #12.5 clk = ~clk;

  always @(posedge clk) begin
    oeHit <= oeHit | spiMisoOe;
    for (int i = 0; i < 4; i++) begin
      cnt[i] <= cnt[i] + {7'h0, pls[i]};
    end
  end

  channel_pin_trigger_config_regs #(.FILTER_CYCLES(filtCycles)) dut (
    .clk, .reset_n, .spiCsNPin, .spiSclkPin, .spiMosiPin, .spiMisoOut, .spiMisoOe,
    .chipAddrPin, .rxFaultFlagA, .rxAvailFlagA, .faultLedPinA, .availLedPinA,
    .startCodeAssignA, .startCodeAssignB, .cycleTimerOnA, .cycleTimerOnB,
    .msgStartA, .msgStartB, .timerStartA, .timerStartB, .inputThresholdTypeA,
    .currentDirA, .currentLevelA, .currentSourceOnA, .currentSinkOnA,
    .lowSidePolarityA, .totemPoleA, .lineDriverOffA, .glitchFilterOnA, .txDataA,
    .txEnA, .linePinAOut, .linePinAOe, .linePinAIn, .lineRxDataA
  );

  spi_host_model host (
    .clk, .csN(spiCsNPin), .sclk(spiSclkPin), .mosi(spiMosiPin), .miso(spiMisoOut)
  );

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [1:0] ca, input logic [4:0] a, input logic [7:0] d);
    logic [7:0] r;
    host.xfer({1'b0, ca, a, d}, r);
  endtask

  task automatic rd(input logic [1:0] ca, input logic [4:0] a, output logic [7:0] r);
    host.xfer({1'b1, ca, a, 8'h00}, r);
  endtask

  task automatic test_done;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic t_reset;
    logic [7:0] r;
    chk("cfg pins", cfgOut, 8'h00);
    rd(ownAddr, `OFS_INDICATOR, r);
    chk("ind reset", r, 8'h00);
    rd(ownAddr, `OFS_LINE_CFG_A, r);
    chk("cfg reset", r, 8'h00);
    rd(ownAddr, 5'h1F, r);
    chk("unmapped", r, 8'h00);
    chk("miso enable", {6'h0, oeHit, spiMisoOe}, 8'h02);
  endtask

  task automatic t_cfg;
    logic [7:0] tbl [4] = '{8'h9A, 8'h65, 8'hF1, 8'h8E};
    logic [7:0] r;
    host.half = 4;
    foreach (tbl[i]) begin
      wr(ownAddr, `OFS_LINE_CFG_A, tbl[i]);
      rd(ownAddr, `OFS_LINE_CFG_A, r);
      chk("cfg read", r, tbl[i]);
      chk("cfg pins", cfgOut, tbl[i]);
      chk("src snk", {6'h0, currentSourceOnA, currentSinkOnA}, {6'h0,
          tbl[i][6] && tbl[i][5:4] != 2'h0, !tbl[i][6] && tbl[i][5:4] != 2'h0});
    end
    wr(2'h1, `OFS_LINE_CFG_A, 8'h00);
    rd(ownAddr, `OFS_LINE_CFG_A, r);
    chk("foreign write", r, 8'h8E);
    rd(2'h1, `OFS_LINE_CFG_A, r);
    chk("foreign read", r, 8'h00);
    host.half = 6;
  endtask

  task automatic t_line;
    logic [7:0] md [5] = '{8'h04, 8'h0C, 8'h08, 8'h00, 8'h06};
    logic [1:0] e;
    foreach (md[m]) begin
      wr(ownAddr, `OFS_LINE_CFG_A, md[m]);
      for (int d = 0; d < 2; d++) begin
        txEnA   <= 1'b1;
        txDataA <= d[0];
        repeat (3) @(posedge clk);
        e[1] = md[m][1] ? 1'b0 : md[m][2] ? 1'b1 : md[m][3] ? !d[0] : d[0];
        e[0] = e[1] && (md[m][2] ? d[0] : !md[m][3]);
        chk("line pin", {6'h0, linePinAOe, linePinAOe && linePinAOut}, {6'h0, e});
      end
    end
    txEnA <= 1'b0;
  endtask

  task automatic t_filt;
    wr(ownAddr, `OFS_LINE_CFG_A, 8'h01);
    repeat (filtCycles + 6) @(posedge clk);
    chk("filter idle", {7'h0, lineRxDataA}, 8'h00);
    lineIdle <= 1'b1;
    repeat (filtCycles - 1) @(posedge clk);
    lineIdle <= 1'b0;
    repeat (filtCycles + 6) @(posedge clk);
    chk("short glitch", {7'h0, lineRxDataA}, 8'h00);
    lineIdle <= 1'b1;
    repeat (filtCycles + 6) @(posedge clk);
    chk("long pulse", {7'h0, lineRxDataA}, 8'h01);
    wr(ownAddr, `OFS_LINE_CFG_A, 8'h00);
    lineIdle <= 1'b0;
    repeat (4) @(posedge clk);
    chk("filter off", {7'h0, lineRxDataA}, 8'h00);
  endtask

  task automatic t_ind;
    logic [7:0] md [4] = '{8'h0A, 8'h00, 8'h05, 8'h0F};
    logic [7:0] r;
    logic [1:0] e;
    foreach (md[m]) begin
      wr(ownAddr, `OFS_INDICATOR, md[m]);
      rd(ownAddr, `OFS_INDICATOR, r);
      chk("ind read", r, md[m]);
      for (int f = 0; f < 4; f++) begin
        rxFaultFlagA <= f[1];
        rxAvailFlagA <= f[0];
        repeat (5) @(posedge clk);
        e[1] = md[m][2] ? f[1] : md[m][3];
        e[0] = md[m][0] ? f[0] : md[m][1];
        chk("ind pins", {6'h0, faultLedPinA, availLedPinA}, {6'h0, e});
      end
    end
  endtask

  task automatic trig(input logic [1:0] ca, input logic [3:0] c, input logic [3:0] exp);
    logic [3:0][7:0] b;
    b = cnt;
    wr(ca, `OFS_TRIGGER, {4'h0, c});
    repeat (8) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      chk("start pulses", cnt[i] - b[i], {7'h0, exp[i]});
    end
  endtask

  task automatic t_trig;
    logic [7:0] r;
    trig(2'h1, 4'h5, 4'hC);
    trig(ownAddr, 4'h9, 4'h3);
    trig(ownAddr, 4'h3, 4'h0);
    trig(ownAddr, 4'h9, 4'h3);
    cycleTimerOnA    <= 1'b0;
    startCodeAssignB <= 4'h5;
    trig(2'h0, 4'h5, 4'hB);
    rd(ownAddr, `OFS_TRIGGER, r);
    chk("trig read", r, 8'h00);
  endtask

  initial begin
    reset_n          = 1'b0;
    chipAddrPin      = ownAddr;
    rxFaultFlagA     = 1'b0;
    rxAvailFlagA     = 1'b0;
    startCodeAssignA = 4'h5;
    startCodeAssignB = 4'h9;
    cycleTimerOnA    = 1'b1;
    cycleTimerOnB    = 1'b1;
    txDataA          = 1'b0;
    txEnA            = 1'b0;
    lineIdle         = 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset;
    t_cfg;
    t_line;
    t_filt;
    t_ind;
    t_trig;
    test_done;
  end

  // about six times the expected run
  initial begin
    #1000000;
    n_fail++;
    test_done;
  end
endmodule

`default_nettype wire
